/* File: sril_defines.svh */
// Constants for the start/restart interlock block
`ifndef SRIL_DEFINES_SVH
`define SRIL_DEFINES_SVH
`define SRIL_CLK_MHZ          200
`define SRIL_PRESS_MIN_MS     120
`define SRIL_PRESS_MAX_MS     4000
`define SRIL_PRESS_MIN_CYC    (`SRIL_PRESS_MIN_MS * 1000 * `SRIL_CLK_MHZ)
`define SRIL_PRESS_MAX_CYC    (`SRIL_PRESS_MAX_MS * 1000 * `SRIL_CLK_MHZ)
`define SRIL_BANK_W           4
`define SRIL_NUM_BANKS        10
`define SRIL_SPEED_W          16
`define SRIL_RESP_W           24
`define SRIL_RES_30           3'h0
`define SRIL_RES_40           3'h1
`define SRIL_RES_50           3'h2
`define SRIL_RES_60           3'h3
`define SRIL_RES_70           3'h4
`define SRIL_RES_150          3'h5
`endif

/* File: sril_pkg.sv */
// Types for the start/restart interlock block
`default_nettype none
package sril_pkg;
  typedef enum logic [1:0]
  {
    SRIL_AUTO      = 2'b00,
    SRIL_START_LCK = 2'b01,
    SRIL_FULL_LCK  = 2'b10
  } sril_mode_e;
  typedef enum logic [1:0]
  {
    SRIL_ST_LOCKED  = 2'b00,
    SRIL_ST_ON      = 2'b01,
    SRIL_ST_WAITFREE= 2'b10
  } sril_state_e;
  typedef logic [2:0] sril_res_t;
endpackage
`default_nettype wire

/* File: sril_interlock.sv */
// Start/restart interlock with per-bank safety parameters
//
// Summary of operation
// - One resolution code per bank, values 30 to 150 mm.
// - One vehicle speed limit per bank, shared by its field pairs.
// - Signals off 5 clocks after field violation; bank response time is only passed out.
// - One start-up mode per bank: auto, start lock, full lock.
// - Auto mode enables at power-up and on field free, no reset.
// - Start lock mode stays off after power-up until valid reset.
// - Start lock mode re-enables automatically once field is free.
// - Pending lock released only by press held 0.12 s to 4 s.
// - Full lock mode stays off after violation until valid reset.
// - Interlock modes never enable automatically at switch-on.
// - Full lock needs reset both at power-up and after clearing.
// - Field violation drops the function A field-clear signal.
`timescale 1ns/1ps
`default_nettype none
`include "sril_defines.svh"
module sril_interlock
#(
  parameter int NUM_BANKS = `SRIL_NUM_BANKS,
  parameter int PRESS_MIN = `SRIL_PRESS_MIN_CYC,
  parameter int PRESS_MAX = `SRIL_PRESS_MAX_CYC
)
(
  input  wire logic                                 clock,
  input  wire logic                                 reset_n,
  input  wire logic [`SRIL_BANK_W-1:0]             bankSel,
  input  wire logic [NUM_BANKS*2-1:0]              bankModeCfg,
  input  wire logic [NUM_BANKS*3-1:0]              bankResCfg,
  input  wire logic [NUM_BANKS*`SRIL_SPEED_W-1:0]  bankSpeedCfg,
  input  wire logic [NUM_BANKS*`SRIL_RESP_W-1:0]   bankRespCfg,
  input  wire logic                                 fieldViolated,
  input  wire logic                                 resetButton,
  output var  logic                                 func_a_field_clear,
  output var  logic                                 start_restart_lock,
  output var  sril_pkg::sril_res_t                  activeRes,
  output var  logic [`SRIL_SPEED_W-1:0]            vehicle_speed_limit,
  output var  logic [`SRIL_RESP_W-1:0]             respTimeCyc
);
  import sril_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] btnSync_q;
  logic [2:0] fldSync_q;
  logic       btn_q;
  logic       fld_q;
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      btnSync_q <= 3'h0;
      fldSync_q <= 3'h7;
      btn_q     <= 1'b0;
      fld_q     <= 1'b1;
    end
    else
    begin
      btnSync_q <= {btnSync_q[1:0], resetButton};
      fldSync_q <= {fldSync_q[1:0], fieldViolated};
      if (btnSync_q[1] == btnSync_q[2])
        btn_q <= btnSync_q[2];
      if (fldSync_q[1] == fldSync_q[2])
        fld_q <= fldSync_q[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank parameter selection
  logic [`SRIL_BANK_W-1:0] bankIdx;
  assign bankIdx = (int'(bankSel) < NUM_BANKS) ? bankSel : '0;
  sril_mode_e mode;
  always_comb
  begin
    case (bankModeCfg[bankIdx*2 +: 2])
      2'b00:   mode = SRIL_AUTO;
      2'b01:   mode = SRIL_START_LCK;
      default: mode = SRIL_FULL_LCK;
    endcase
  end
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      activeRes           <= `SRIL_RES_30;
      vehicle_speed_limit <= '0;
      respTimeCyc         <= '0;
    end
    else
    begin
      activeRes           <= bankResCfg[bankIdx*3 +: 3];
      vehicle_speed_limit <= bankSpeedCfg[bankIdx*`SRIL_SPEED_W +: `SRIL_SPEED_W];
      respTimeCyc         <= bankRespCfg[bankIdx*`SRIL_RESP_W +: `SRIL_RESP_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset button press timing
  logic [31:0] pressCnt_q;
  logic        btnPrev_q;
  logic        validPress_q;
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      pressCnt_q   <= 32'h0000_0000;
      btnPrev_q    <= 1'b0;
      validPress_q <= 1'b0;
    end
    else
    begin
      btnPrev_q    <= btn_q;
      validPress_q <= 1'b0;
      if (btn_q)
      begin
        if (pressCnt_q <= 32'(PRESS_MAX))
          pressCnt_q <= pressCnt_q + 32'h0000_0001;
      end
      else
      begin
        pressCnt_q <= 32'h0000_0000;
        if (btnPrev_q && pressCnt_q >= 32'(PRESS_MIN) && pressCnt_q <= 32'(PRESS_MAX))
          validPress_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interlock state machine
  sril_state_e state_q;
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      state_q <= SRIL_ST_LOCKED;
    else
    begin
      case (state_q)
        SRIL_ST_LOCKED:
        begin
          if (mode == SRIL_AUTO && !fld_q)
            state_q <= SRIL_ST_ON;
          else if (mode != SRIL_AUTO && validPress_q && !fld_q)
            state_q <= SRIL_ST_ON;
        end
        SRIL_ST_ON:
        begin
          if (fld_q)
            state_q <= (mode == SRIL_FULL_LCK) ? SRIL_ST_LOCKED : SRIL_ST_WAITFREE;
        end
        SRIL_ST_WAITFREE:
        begin
          if (mode == SRIL_FULL_LCK)
            state_q <= SRIL_ST_LOCKED;
          else if (!fld_q)
            state_q <= SRIL_ST_ON;
        end
        default: state_q <= SRIL_ST_LOCKED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      func_a_field_clear <= 1'b0;
      start_restart_lock <= 1'b1;
    end
    else
    begin
      func_a_field_clear <= (state_q == SRIL_ST_ON) && !fld_q;
      start_restart_lock <= (state_q == SRIL_ST_LOCKED);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  violation_off_a: assert property (@(posedge clock) disable iff (!reset_n)
    fld_q |=> !func_a_field_clear) else $error("Signal on during violation");
  resp_time_a: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(fld_q) |-> ##[1:2] !func_a_field_clear) else $error("Late switch-off");
  full_relock_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == SRIL_ST_ON && fld_q && mode == SRIL_FULL_LCK) |=> state_q == SRIL_ST_LOCKED)
    else $error("Full lock did not relock");
  lock_needs_press_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == SRIL_ST_LOCKED && mode != SRIL_AUTO && !validPress_q) |=> state_q != SRIL_ST_ON)
    else $error("Interlock released without press");
  auto_start_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == SRIL_ST_LOCKED && mode == SRIL_AUTO && !fld_q) |=> state_q == SRIL_ST_ON)
    else $error("Auto mode did not start");
  auto_restart_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == SRIL_ST_WAITFREE && mode == SRIL_START_LCK && !fld_q) |=> state_q == SRIL_ST_ON)
    else $error("Start lock mode did not restart");
  press_window_a: assert property (@(posedge clock) disable iff (!reset_n)
    validPress_q |-> $past(pressCnt_q) >= 32'(PRESS_MIN) && $past(pressCnt_q) <= 32'(PRESS_MAX))
    else $error("Press accepted outside window");
  long_press_a: assert property (@(posedge clock) disable iff (!reset_n)
    ($fell(btn_q) && $past(pressCnt_q) > 32'(PRESS_MAX)) |=> !validPress_q)
    else $error("Overlong press accepted");
  lock_output_a: assert property (@(posedge clock) disable iff (!reset_n)
    start_restart_lock |-> !func_a_field_clear) else $error("Locked yet clear");
  res_select_a: assert property (@(posedge clock) disable iff (!reset_n)
    $past(reset_n) && $stable(bankSel) && $stable(bankResCfg)
    |-> activeRes == bankResCfg[bankIdx*3 +: 3])
    else $error("Resolution not from bank");
  speed_select_a: assert property (@(posedge clock) disable iff (!reset_n)
    $past(reset_n) && $stable(bankSel) && $stable(bankSpeedCfg)
    |-> vehicle_speed_limit == bankSpeedCfg[bankIdx*`SRIL_SPEED_W +: `SRIL_SPEED_W])
    else $error("Speed not from bank");
  mode_one_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == SRIL_ST_WAITFREE && mode == SRIL_FULL_LCK) |=> state_q == SRIL_ST_LOCKED)
    else $error("Bank mode not applied");
  press_release_c: cover property (@(posedge clock) disable iff (!reset_n)
    state_q == SRIL_ST_LOCKED ##1 validPress_q ##1 state_q == SRIL_ST_ON);
  auto_restart_c: cover property (@(posedge clock) disable iff (!reset_n)
    state_q == SRIL_ST_WAITFREE ##1 state_q == SRIL_ST_ON);
  full_relock_c: cover property (@(posedge clock) disable iff (!reset_n)
    state_q == SRIL_ST_ON ##1 state_q == SRIL_ST_LOCKED);
endmodule
`default_nettype wire

/* File: sril_machine_model.sv */
// Machine control model fed by the safety switching signals
`timescale 1ns/1ps
`default_nettype none
module sril_machine_model
(
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic fieldClear,
  input  wire logic lockPending,
  output var  logic machineRun_q
);
  // Runs only once the sensor has released its signals
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      machineRun_q <= 1'b0;
    else
      machineRun_q <= fieldClear & ~lockPending;
  end
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the start/restart interlock
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sril_pkg::*;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  bankSel = 4'h0;
  logic [3:0]  bankModeCfg = 4'h0;
  logic [5:0]  bankResCfg = 6'h0;
  logic [31:0] bankSpeedCfg = 32'h0;
  logic [47:0] bankRespCfg = 48'h0;
  logic        fieldViolated = 1'b0;
  logic        resetButton = 1'b0;
  logic        clr, lock, run;
  logic        chk = 1'b0;
  sril_res_t   res;
  logic [15:0] spd;
  logic [23:0] rsp;
  logic [45:0] expQ[$];
  logic [45:0] expV;
  int          fails = 0;
  int          total_checks = 0;
  integer      seed = 28488;
  sril_interlock #(.NUM_BANKS(2), .PRESS_MIN(10), .PRESS_MAX(50)) uut
  (.clock(clock), .reset_n(reset_n), .bankSel(bankSel), .bankModeCfg(bankModeCfg),
   .bankResCfg(bankResCfg), .bankSpeedCfg(bankSpeedCfg), .bankRespCfg(bankRespCfg),
   .fieldViolated(fieldViolated), .resetButton(resetButton), .func_a_field_clear(clr),
   .start_restart_lock(lock), .activeRes(res), .vehicle_speed_limit(spd), .respTimeCyc(rsp));
  sril_machine_model mc
  (.clock(clock), .reset_n(reset_n), .fieldClear(clr), .lockPending(lock), .machineRun_q(run));
  initial forever #2.5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic note(input logic c, input logic l, input int b);
    expQ.push_back({c, l, bankResCfg[b*3+:3], bankSpeedCfg[b*16+:16],
                    bankRespCfg[b*24+:24], c & ~l});
    chk <= 1'b1;
    tick(1);
    chk <= 1'b0;
    tick(1);
  endtask
  task automatic restart(input logic [1:0] m);
    reset_n <= 1'b0;
    bankModeCfg <= {m, m};
    tick(8);
    reset_n <= 1'b1;
    tick(12);
  endtask
  task automatic press(input int d);
    resetButton <= 1'b1;
    tick(d);
    resetButton <= 1'b0;
    tick(12);
  endtask
  task automatic field(input logic v);
    fieldViolated <= v;
    tick(12);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Oldest note against the settled outputs
  always @(posedge clock)
  begin
    if (chk)
    begin
      expV = expQ.pop_front();
      total_checks++;
      if ({clr, lock, res, spd, rsp, run} !== expV)
      begin
        fails++;
        $display("mismatch outputs expected %h seen %h", expV, {clr, lock, res, spd, rsp, run});
      end
    end
  end
  initial
  begin
    tick(3000);
    fails++;
    give_verdict();
  end
  initial
  begin
    bankResCfg <= {3'({$random(seed)} % 6), 3'({$random(seed)} % 6)};
    bankSpeedCfg <= $random(seed);
    bankRespCfg <= 48'({$random(seed), $random(seed)});
    restart(2'd0);
    note(1'b1, 1'b0, 0);
    bankSel <= 4'h1;
    tick(6);
    note(1'b1, 1'b0, 1);
    bankSel <= 4'hf;
    tick(6);
    note(1'b1, 1'b0, 0);
    field(1'b1);
    note(1'b0, 1'b0, 0);
    field(1'b0);
    note(1'b1, 1'b0, 0);
    restart(2'd1);
    note(1'b0, 1'b1, 0);
    press(5);
    note(1'b0, 1'b1, 0);
    press(70);
    note(1'b0, 1'b1, 0);
    press(20);
    note(1'b1, 1'b0, 0);
    field(1'b1);
    note(1'b0, 1'b0, 0);
    field(1'b0);
    note(1'b1, 1'b0, 0);
    // Both codes of the full lock mode
    for (int m = 2; m < 4; m++)
    begin
      restart(2'(m));
      note(1'b0, 1'b1, 0);
      press(20);
      note(1'b1, 1'b0, 0);
      field(1'b1);
      press(20);
      field(1'b0);
      note(1'b0, 1'b1, 0);
      press(20);
      note(1'b1, 1'b0, 0);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
